// ===== hw/smsup_top.sv
// operating-mode supervisor: wake, fail-safe, fault, watchdog, channel targets
// pins and fault lines are asynchronous; config and spi word strobes are on clk
`timescale 1ns/100ps
module smsup_top
    import smsup_pkg::*;
#(
    parameter int unsigned WDTO_CYC = WDTO_CYCLES_DEF,
    parameter int unsigned ACT_CYC = ACT_CYCLES_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wake_reset_pin,
    input wire logic [NCH-1:0] direct_input,
    input wire logic logic_supply_ok,
    input wire smsup_fault_t faults,
    input wire smsup_cfg_t cfg,
    input wire smsup_chan_t [NCH-1:0] chan_cfg,
    input wire logic word_valid,
    input wire logic watchdog_toggle_bit,
    output logic [NCH-1:0] switch_on,
    output logic [NCH-1:0][SLEW_W-1:0] slew_select,
    output smsup_mode_t mode,
    output logic normal_mode_flag,
    output logic failsafe_output_n,
    output logic failsafe_output_oe,
    output logic serial_if_enable,
    output logic serial_reset,
    output logic fault_delatch,
    output logic serial_access_block
);
    localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WDTO_CYC - 1);

    // two-stage synchroniser for all asynchronous inputs
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= {wake_reset_pin, direct_input, logic_supply_ok, faults};
            sync2 <= sync1;
        end
    end

    logic wake_s;
    logic [NCH-1:0] direct_s;
    logic logic_ok_s;
    smsup_fault_t fault_s;
    assign {wake_s, direct_s, logic_ok_s, fault_s} = sync2;

    // input activity flags, one timer per direct input
    logic [NCH-1:0] activity;
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_act
            smsup_activity_timer #(.TIMEOUT_CYC(ACT_CYC)) u_act (
                .clk(clk),
                .rst_n(rst_n),
                .in_level(direct_s[g]),
                .active(activity[g])
            );
        end
    endgenerate

    // mode-deciding signals
    logic wake;
    logic any_fault;
    logic [NCH-1:0] ch_fault;
    logic supply_fault;
    assign wake = wake_s | (|activity);
    assign supply_fault = fault_s.undervoltage_fault
        | (fault_s.excess_supply_fault & cfg.excess_supply_qualifier);
    assign ch_fault = fault_s.overcurrent_fault | fault_s.overtemperature_fault
        | fault_s.short_circuit_fault | {NCH{supply_fault}};
    assign any_fault = |ch_fault;

    // watchdog and fail-safe state
    logic wake_prev;
    logic wd_armed;
    logic toggle_prev;
    logic [CNT_W-1:0] wd_count;
    logic fs_flag;
    logic rec_stage;
    logic supply_seen;
    logic next_wake_prev;
    logic next_wd_armed;
    logic next_toggle_prev;
    logic [CNT_W-1:0] next_wd_count;
    logic next_fs_flag;
    logic next_rec_stage;
    logic next_supply_seen;
    logic wd_run;
    logic wd_last;
    logic toggle_change;
    logic fs_set;
    logic fs_clear;

    assign wd_run = wd_armed && mode == MODE_NORMAL && logic_ok_s
        && !cfg.watchdog_disable_bit && wake_s;
    assign wd_last = wd_count == WD_LAST;
    assign toggle_change = word_valid && watchdog_toggle_bit != toggle_prev;

    // watchdog counter, fail-safe cause and recovery sequence
    always_comb
    begin
        next_wake_prev = wake_s;
        next_toggle_prev = word_valid ? watchdog_toggle_bit : toggle_prev;
        next_supply_seen = supply_seen | logic_ok_s;
        next_wd_armed = wd_armed;
        next_wd_count = wd_count;
        next_rec_stage = rec_stage;
        fs_set = 1'b0;
        fs_clear = 1'b0;
        if (!logic_ok_s || !wake_s)
            next_wd_armed = 1'b0;
        else if (!wake_prev)
            next_wd_armed = 1'b1; // rising edge starts the timer
        if (supply_seen && !logic_ok_s && cfg.logic_supply_loss_enable)
            fs_set = 1'b1;
        if (fs_flag)
        begin
            // recovery: a toggle-one word opens a window for a second word
            if (!rec_stage)
            begin
                next_wd_count = CNT_ZERO;
                if (word_valid && watchdog_toggle_bit && logic_ok_s)
                    next_rec_stage = 1'b1;
            end
            else if (word_valid && logic_ok_s)
            begin
                fs_clear = 1'b1;
                next_rec_stage = 1'b0;
                next_wd_count = CNT_ZERO;
            end
            else if (wd_last)
            begin
                next_rec_stage = 1'b0; // window missed, start over
                next_wd_count = CNT_ZERO;
            end
            else
                next_wd_count = wd_count + CNT_ONE;
        end
        else if (!wd_run || toggle_change)
            next_wd_count = CNT_ZERO;
        else if (wd_last)
        begin
            fs_set = 1'b1; // communication lost
            next_wd_count = CNT_ZERO;
        end
        else
            next_wd_count = wd_count + CNT_ONE;
        // a new cause in the clearing cycle keeps the flag set
        next_fs_flag = fs_set | (fs_flag & ~fs_clear);
        if (next_fs_flag && !fs_flag)
            next_rec_stage = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wake_prev <= 1'b0;
            wd_armed <= 1'b0;
            toggle_prev <= 1'b0;
            wd_count <= CNT_ZERO;
            fs_flag <= 1'b0;
            rec_stage <= 1'b0;
            supply_seen <= 1'b0;
        end
        else
        begin
            wake_prev <= next_wake_prev;
            wd_armed <= next_wd_armed;
            toggle_prev <= next_toggle_prev;
            wd_count <= next_wd_count;
            fs_flag <= next_fs_flag;
            rec_stage <= next_rec_stage;
            supply_seen <= next_supply_seen;
        end
    end

    // mode selection; sleep wins, then fault, then fail-safe
    smsup_mode_t next_mode;
    always_comb
    begin
        if (!wake)
            next_mode = MODE_SLEEP;
        else if (any_fault)
            next_mode = MODE_FAULT; // fail-safe value ignored
        else if (fs_flag)
            next_mode = MODE_FAILSAFE;
        else
            next_mode = MODE_NORMAL;
    end

    // channel targets; direct-only when pin low or in fail-safe
    logic direct_only;
    logic [NCH-1:0] next_switch;
    logic [NCH-1:0][SLEW_W-1:0] next_slew;
    assign direct_only = !wake_s || fs_flag;
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            logic pwm_sig;
            logic spi_path;
            logic dir_path;
            pwm_sig = chan_cfg[i].clock_internal ? chan_cfg[i].duty_internal
                : chan_cfg[i].duty_external;
            spi_path = chan_cfg[i].on_bit && ((pwm_sig && chan_cfg[i].pwm_enable)
                || !chan_cfg[i].pwm_enable);
            dir_path = direct_s[i] && !chan_cfg[i].direct_input_disable;
            if (direct_only)
                next_switch[i] = wake && direct_s[i] && !ch_fault[i];
            else
                next_switch[i] = wake && (dir_path || spi_path) && !ch_fault[i];
            if (direct_only || !spi_path)
                next_slew[i] = SLEW_DEFAULT;
            else
                next_slew[i] = chan_cfg[i].slew_code;
        end
    end

    // registered outputs; reset state is sleep with registers held
    logic next_serial_reset;
    logic next_delatch;
    assign next_serial_reset = (next_mode == MODE_SLEEP)
        || (next_fs_flag && !fs_flag);
    assign next_delatch = next_fs_flag && !fs_flag;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode <= MODE_SLEEP;
            normal_mode_flag <= 1'b0;
            switch_on <= '0;
            slew_select <= '0;
            failsafe_output_n <= 1'b0;
            failsafe_output_oe <= 1'b0;
            serial_if_enable <= 1'b0;
            serial_reset <= 1'b1;
            fault_delatch <= 1'b0;
            serial_access_block <= 1'b1;
        end
        else
        begin
            mode <= next_mode;
            normal_mode_flag <= next_mode == MODE_NORMAL;
            switch_on <= next_switch;
            slew_select <= next_slew;
            failsafe_output_n <= 1'b0; // open drain: only ever pulls low
            failsafe_output_oe <= next_fs_flag;
            serial_if_enable <= next_mode != MODE_SLEEP;
            serial_reset <= next_serial_reset;
            fault_delatch <= next_delatch;
            serial_access_block <= next_fs_flag || next_mode == MODE_SLEEP;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fs_rise;
        !fs_flag ##1 fs_flag;
    endsequence
    sequence s_first_word;
        fs_flag && !rec_stage && word_valid && watchdog_toggle_bit && logic_ok_s;
    endsequence

    a_sleep_wake: assert property (!wake |=> mode == MODE_SLEEP
        && switch_on == '0 && !serial_if_enable)
        else $error("sleep not entered without wake");
    a_fault_mode: assert property (wake && any_fault |=> mode == MODE_FAULT)
        else $error("fault did not select fault mode");
    a_fault_off: assert property (ch_fault[0] |=> !switch_on[0])
        else $error("faulty channel left on");
    a_nm_flag: assert property ($rose(normal_mode_flag) |->
        $past(wake && !any_fault && !fs_flag) && mode == MODE_NORMAL)
        else $error("normal flag without normal conditions");
    a_fs_entry: assert property (s_fs_rise |-> serial_reset
        && fault_delatch && failsafe_output_oe && serial_access_block)
        else $error("fail-safe entry actions missing");
    a_wd_expire: assert property (!fs_flag && wd_run && wd_last && !toggle_change
        |=> fs_flag)
        else $error("watchdog expiry did not enter fail-safe");
    // judged on the flag itself, so a timer that ignores the disable bit is caught
    a_wd_disable: assert property (!fs_flag && cfg.watchdog_disable_bit
        && !(supply_seen && !logic_ok_s && cfg.logic_supply_loss_enable)
        |=> !fs_flag)
        else $error("watchdog entered fail-safe while disabled");
    a_wd_restart: assert property (!fs_flag && toggle_change |=> wd_count == CNT_ZERO)
        else $error("toggle change did not restart watchdog");
    a_fs_leave: assert property (s_first_word ##1 (word_valid && logic_ok_s
        && !fs_set) |=> !fs_flag && !failsafe_output_oe)
        else $error("fail-safe not left after two words");
    a_direct_only: assert property (direct_only |=>
        switch_on == $past(direct_s & ~ch_fault & {NCH{wake}}))
        else $error("channels not following direct inputs");
    a_slew_dflt: assert property (direct_only |=> slew_select == '0)
        else $error("direct control used programmed slew");
endmodule : smsup_top

// ===== pkg/smsup_pkg.sv
// mode supervisor constants, carrier structs and mode encoding
// assumes a single 100 MHz clock and synchronous active-low reset
// Contract
// - wake is pin or either activity flag
// - fail-safe on supply loss or watchdog timeout
// - fault is OR of channel and supply faults
// - wake with fault gives Fault mode, channel off
// - sleep turns channels and serial interface off
// - watchdog runs only when supply, enabled, pin high
// - watchdog starts on wake pin rising edge
// - no toggle within timeout enters Fail-safe
// - disable bit blocks watchdog fail-safe entry
// - pin or direct input rise enters Normal
// - normal_mode_flag high in Normal mode
// - activity flag clears after quiet timeout
// - both flags low, pin low gives Sleep
// - pin low or fail-safe: direct inputs only
// - target state equation per channel
// - direct control uses default slew code
// - external clock mode takes external duty signal
// - sleep after power-up, registers held default
// - fail-safe entry: pin low, delatch, reset, block
// - toggle-one word then second word leaves Fail-safe
package smsup_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WDTO_MS = 310;
    localparam int unsigned ACT_MS = 250;
    localparam int unsigned WDTO_CYCLES_DEF = WDTO_MS * 1000 * CLK_MHZ;
    localparam int unsigned ACT_CYCLES_DEF = ACT_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 25;
    localparam int SLEW_W = 2;
    localparam int NCH = 2;
    localparam logic [SLEW_W-1:0] SLEW_DEFAULT = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;

    // analog fault indications, pin side
    typedef struct packed {
        logic [1:0] overcurrent_fault;
        logic [1:0] overtemperature_fault;
        logic [1:0] short_circuit_fault;
        logic undervoltage_fault;
        logic excess_supply_fault;
    } smsup_fault_t;

    // global configuration bits from the serial registers
    typedef struct packed {
        logic watchdog_disable_bit;
        logic logic_supply_loss_enable;
        logic excess_supply_qualifier;
    } smsup_cfg_t;

    // per-channel configuration and pwm compare signals
    typedef struct packed {
        logic on_bit;
        logic pwm_enable;
        logic direct_input_disable;
        logic clock_internal;
        logic duty_internal;
        logic duty_external;
        logic [SLEW_W-1:0] slew_code;
    } smsup_chan_t;

    typedef enum logic [3:0] {
        MODE_SLEEP = 4'h1,
        MODE_NORMAL = 4'h2,
        MODE_FAILSAFE = 4'h4,
        MODE_FAULT = 4'h8
    } smsup_mode_t;

    localparam int SYNC_W = 4 + $bits(smsup_fault_t);
endpackage : smsup_pkg

// ===== hw/smsup_activity_timer.sv
// per-channel direct input activity detector
// expects an input already synchronised to clk
`timescale 1ns/100ps
module smsup_activity_timer
    import smsup_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = ACT_CYCLES_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_level,
    output logic active
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);
    logic prev;
    logic [CNT_W-1:0] count;
    logic next_prev;
    logic next_active;
    logic [CNT_W-1:0] next_count;

    // any edge counts as activity; a rise also sets the flag
    always_comb
    begin
        next_prev = in_level;
        next_active = active;
        next_count = count;
        if (in_level != prev)
        begin
            next_count = CNT_ZERO;
            if (in_level)
                next_active = 1'b1;
        end
        else if (active)
        begin
            if (count == LAST)
                next_active = 1'b0; // quiet too long
            else
                next_count = count + CNT_ONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev <= 1'b0;
            active <= 1'b0;
            count <= CNT_ZERO;
        end
        else
        begin
            prev <= next_prev;
            active <= next_active;
            count <= next_count;
        end
    end

    a_act_rise: assert property (@(posedge clk) disable iff (!rst_n)
        (in_level && !prev) |=> active && count == CNT_ZERO)
        else $error("activity flag not set on input rise");
    a_act_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (active && in_level == prev && count == LAST) |=> !active)
        else $error("activity flag not cleared at timeout");
endmodule : smsup_activity_timer

// ===== test/smsup_host_model.sv
// host-side model: sends spi word strobes with the watchdog toggle bit
// assumes the supervisor samples word_valid and the bit on the rising edge of clk
`timescale 1ns/100ps
module smsup_host_model
    import smsup_pkg::*;
#(
    parameter int GAP = 50
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic keepalive,
    input wire logic shot,
    input wire logic shot_bit,
    output logic word_valid,
    output logic watchdog_toggle_bit
);
    int cnt;
    logic last;

    // outside a word the bit line shows the inverse, so a stale value never passes
    assign watchdog_toggle_bit = word_valid ? last : ~last;

    // periodic keepalive words, or one word on request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            word_valid <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            word_valid <= 1'b0;
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            if (shot)
            begin
                word_valid <= 1'b1;
                last <= shot_bit;
            end
            else if (keepalive && cnt == GAP - 1)
            begin
                word_valid <= 1'b1;
                last <= ~last;
            end
        end
    end
endmodule : smsup_host_model

// ===== test/tb.sv
// self-checking bench for the mode supervisor with a host model
// assumes short watchdog and activity counts so the run stays brief
`timescale 1ns/100ps
module tb
    import smsup_pkg::*;
;
    localparam int unsigned WD = 200;
    localparam int unsigned ACT = 100;
    localparam smsup_chan_t CH_ON = '{on_bit: 1'b1, default: '0};
    logic clk, rst_n, pin, sup, wv, wbit, keep, shot, shot_bit;
    logic nm, fs_n, fs_oe, sie, srst, fdl, sab;
    logic [NCH-1:0] din, sw;
    logic [NCH-1:0][SLEW_W-1:0] slew;
    smsup_fault_t flt;
    smsup_cfg_t cfg;
    smsup_chan_t [NCH-1:0] cc;
    smsup_mode_t mode;
    int n_fail, checks_done, cyc;

    smsup_top #(.WDTO_CYC(WD), .ACT_CYC(ACT)) smsup_top_i (.clk(clk), .rst_n(rst_n),
        .wake_reset_pin(pin), .direct_input(din), .logic_supply_ok(sup), .faults(flt),
        .cfg(cfg), .chan_cfg(cc), .word_valid(wv), .watchdog_toggle_bit(wbit),
        .switch_on(sw), .slew_select(slew), .mode(mode), .normal_mode_flag(nm),
        .failsafe_output_n(fs_n), .failsafe_output_oe(fs_oe), .serial_if_enable(sie),
        .serial_reset(srst), .fault_delatch(fdl), .serial_access_block(sab));

    smsup_host_model #(.GAP(50)) smsup_host_model_i (.clk(clk), .rst_n(rst_n),
        .keepalive(keep), .shot(shot), .shot_bit(shot_bit), .word_valid(wv),
        .watchdog_toggle_bit(wbit));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // wait edges, then let that edge's updates settle before looking
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : go

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // recovery pair: a word with the bit at one, then any second word
    task automatic recover;
        @(posedge clk);
        shot <= 1'b1;
        shot_bit <= 1'b1;
        @(posedge clk);
        shot <= 1'b0;
        go(20);
        @(posedge clk);
        shot <= 1'b1;
        shot_bit <= 1'b0;
        keep <= 1'b1;
        @(posedge clk);
        shot <= 1'b0;
        go(5);
        chk(mode, MODE_NORMAL);
        chk(fs_oe, 1'b0);
    endtask : recover

    task automatic t_wake_watchdog;
        chk(mode, MODE_SLEEP);
        chk(sie, 1'b0);
        @(posedge clk);
        pin <= 1'b1;
        keep <= 1'b1;
        go(4);
        chk(mode, MODE_NORMAL);
        chk(nm, 1'b1);
        chk(sie, 1'b1);
        chk(srst, 1'b0);
        go(600);
        chk(mode, MODE_NORMAL);
        @(posedge clk);
        keep <= 1'b0;
        go(140);
        chk(mode, MODE_NORMAL);
        go(90);
        chk(mode, MODE_FAILSAFE);
        chk({fs_n, fs_oe, sab}, 3'h3);
    endtask : t_wake_watchdog

    // fail-safe: direct inputs only, disable bit and on bit ignored
    task automatic t_failsafe_ctrl;
        @(posedge clk);
        cc[0] <= '{direct_input_disable: 1'b1, slew_code: 2'h3, default: '0};
        cc[1] <= '{on_bit: 1'b1, slew_code: 2'h3, default: '0};
        din <= 2'h1;
        go(5);
        chk(sw, 2'h1);
        chk(slew, 4'h0);
        @(posedge clk);
        din <= 2'h0;
        recover();
        chk(sw, 2'h2);
        chk(slew, 4'hC);
    endtask : t_failsafe_ctrl

    task automatic t_equation;
        logic [6:0] v;
        logic e;
        for (int i = 0; i < 128; i++)
        begin
            v = i[6:0];
            @(posedge clk);
            din <= {1'b0, v[0]};
            cc[1] <= '0;
            cc[0] <= '{on_bit: v[2], pwm_enable: v[3], direct_input_disable: v[1],
                clock_internal: v[4], duty_internal: v[5], duty_external: v[6],
                slew_code: 2'h0};
            go(5);
            e = (v[0] & ~v[1]) | (v[2] & v[3] & (v[4] ? v[5] : v[6])) | (v[2] & ~v[3]);
            chk(sw, {1'b0, e});
        end
    endtask : t_equation

    task automatic t_faults;
        @(posedge clk);
        din <= 2'h0;
        cc <= {CH_ON, CH_ON};
        cfg.excess_supply_qualifier <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            flt <= smsup_fault_t'(8'h01 << i);
            go(5);
            chk(mode, MODE_FAULT);
            chk(sw, (i < 2) ? 2'h0 : (i[0] ? 2'h1 : 2'h2));
            @(posedge clk);
            flt <= '0;
            go(5);
            chk(sw, 2'h3);
        end
        @(posedge clk);
        cfg.excess_supply_qualifier <= 1'b0;
        flt <= smsup_fault_t'(8'h01);
        go(5);
        chk(mode, MODE_NORMAL);
        @(posedge clk);
        flt <= '0;
    endtask : t_faults

    task automatic t_disable_supply;
        @(posedge clk);
        cfg.watchdog_disable_bit <= 1'b1;
        keep <= 1'b0;
        go(300);
        chk(mode, MODE_NORMAL);
        @(posedge clk);
        cfg.logic_supply_loss_enable <= 1'b1;
        sup <= 1'b0;
        go(3);
        chk(fdl, 1'b1);
        chk(srst, 1'b1);
        go(1);
        chk(fdl, 1'b0);
        go(2);
        chk(mode, MODE_FAILSAFE);
        @(posedge clk);
        sup <= 1'b1;
        cfg.logic_supply_loss_enable <= 1'b0;
        recover();
    endtask : t_disable_supply

    // host lets the pin fall; sleep follows once both inputs go quiet
    task automatic t_sleep;
        @(posedge clk);
        pin <= 1'b0;
        cc <= '0;
        go(ACT + 20);
        chk(mode, MODE_SLEEP);
        chk({sw, sie, sab}, 4'h1);
        chk(srst, 1'b1);
        @(posedge clk);
        din <= 2'h1;
        go(5);
        chk(mode, MODE_NORMAL);
        chk(sw, 2'h1);
        go(ACT + 20);
        chk(mode, MODE_SLEEP);
        chk(sw, 2'h0);
    endtask : t_sleep

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the planned sequence needs about 2350 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    initial
    begin
        {rst_n, pin, keep, shot, shot_bit, din, flt, cfg, cc} = '0;
        sup = 1'b1;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        go(1);
        t_wake_watchdog();
        t_failsafe_ctrl();
        t_equation();
        t_faults();
        t_disable_supply();
        t_sleep();
        print_verdict();
    end
endmodule : tb
